//--- logic/startup_fault_pkg.sv
package startup_fault_pkg;
    localparam int          NUM_CH           = 4;
    localparam int          SENSE_W          = 10;
    // Sink pin level thresholds in millivolts.
    localparam logic [9:0]  ACTIVE_MV        = 10'h154;
    localparam logic [9:0]  SHORT_MV         = 10'h078;
    // Short-detect phase length in switching clock cycles.
    localparam logic [11:0] DETECT_CYCLES    = 12'he00;
    // Fault-clear hold counts: 32k cycles, or 8k on the low-frequency part.
    localparam logic [15:0] CLEAR_CYCLES_HI  = 16'h8000;
    localparam logic [15:0] CLEAR_CYCLES_LO  = 16'h2000;
    localparam int          CLR_W            = 16;
    localparam logic [1:0]  CH_IN_USE        = 2'h0;
    localparam logic [1:0]  CH_UNUSED        = 2'h1;
    localparam logic [1:0]  CH_SHORTED       = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_WAIT   = 3'b001,
        ST_UVCHK  = 3'b010,
        ST_DETECT = 3'b011,
        ST_RAMP   = 3'b100,
        ST_LATCH  = 3'b101
    } seq_state_t;

    function automatic logic [1:0] classify(input logic [9:0] mv);
        if (mv > ACTIVE_MV)
            return CH_IN_USE;
        else if (mv < SHORT_MV)
            return CH_SHORTED;
        else
            return CH_UNUSED;
    endfunction : classify
endpackage : startup_fault_pkg

//--- logic/low_hold_counter.sv
`timescale 1ns/1ps
`default_nettype none
module low_hold_counter (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 sw_tick,
    input  wire logic                 level,
    input  wire logic [15:0]          limit,
    output logic                      expired
);
    logic [15:0] cnt_r;

    // The count only runs while the level stays low and restarts on any
    // high, so a short low glitch never clears a latched fault.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 16'h0000;
        end else if (level) begin
            cnt_r <= 16'h0000; // see RULE_11
        end else if (sw_tick && cnt_r <= limit) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    assign expired = (cnt_r > limit) && !level;

    a_restart_on_high: assert property ( // see RULE_11
        @(posedge clk) disable iff (!reset_n)
        level |=> cnt_r == 16'h0000)
        else $error("hold counter did not restart on high level");
endmodule : low_hold_counter
`default_nettype wire

//--- logic/sink_classifier.sv
`timescale 1ns/1ps
`default_nettype none
module sink_classifier (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 sample,
    input  wire logic [39:0]          led_sink_pin_mv,
    output logic      [3:0]           active,
    output logic      [3:0]           shorted
);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            active  <= 4'h0;
            shorted <= 4'h0;
        end else if (sample) begin
            for (int i = 0; i < startup_fault_pkg::NUM_CH; i++) begin
                active[i]  <= startup_fault_pkg::classify(
                    led_sink_pin_mv[i*10 +: 10])
                    == startup_fault_pkg::CH_IN_USE; // see RULE_01
                shorted[i] <= startup_fault_pkg::classify(
                    led_sink_pin_mv[i*10 +: 10])
                    == startup_fault_pkg::CH_SHORTED;
            end
        end
    end
endmodule : sink_classifier
`default_nettype wire

//--- logic/startup_fault_gate.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01: A sink pin above 340 mV is active and lets startup go on.
// RULE_02: A channel found unused is dropped and startup goes on without it.
// RULE_03: While any sink pin is shorted, the ramp and boost stay off.
// RULE_04: Once the short goes away, startup resumes without a clear.
// RULE_05: After the input switch is on, a low output flags a fault.
// RULE_06: An undervoltage fault shuts down at once and stays latched.
// RULE_07: Input supply lockout clears the latched fault.
// RULE_08: Enable low past 32k cycles (8k low-frequency) clears the latch.
// RULE_09: Dimming low with enable high past that count clears the latch.
// RULE_10: The clock output keeps running during a dimming-low clear.
// RULE_11: The low-hold counter restarts when its input returns high early.
// RULE_12: Sink pin checks start only once dimming goes high after enable.
// RULE_13: The short-detect phase lasts 3584 cycles, then the ramp starts.
module startup_fault_gate (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 sw_tick,
    input  wire logic                 low_freq_variant,
    input  wire logic                 enable,
    input  wire logic                 dimming,
    input  wire logic                 input_supply_lockout,
    input  wire logic                 disconnect_on,
    input  wire logic                 output_below_threshold,
    input  wire logic [39:0]          led_sink_pin_mv,
    output logic                      disconnect_enable,
    output logic                      clock_out_enable,
    output logic                      ramp_enable,
    output logic                      boost_enable,
    output logic      [3:0]           channel_enable,
    output logic                      sink_short_fault,
    output logic                      output_undervoltage_fault
);
    startup_fault_pkg::seq_state_t state_r;
    startup_fault_pkg::seq_state_t state_nxt;
    logic [11:0] det_cnt_r;
    logic [3:0]  active;
    logic [3:0]  shorted;
    logic [15:0] limit;
    logic        en_clear;
    logic        dim_clear;
    logic        clear_req;
    logic        det_done;

    assign limit = low_freq_variant ? startup_fault_pkg::CLEAR_CYCLES_LO
                                    : startup_fault_pkg::CLEAR_CYCLES_HI;

    low_hold_counter u_en_hold (
        .clk     (clk),
        .reset_n (reset_n),
        .sw_tick (sw_tick),
        .level   (enable),
        .limit   (limit),
        .expired (en_clear)
    );

    // Enable must stay high for the dimming path, so a low enable restarts
    // that count as well.
    low_hold_counter u_dim_hold (
        .clk     (clk),
        .reset_n (reset_n),
        .sw_tick (sw_tick),
        .level   (dimming || !enable), // see RULE_09
        .limit   (limit),
        .expired (dim_clear)
    );

    // Any of the three clear sources releases the latched fault.
    assign clear_req = input_supply_lockout // see RULE_07
                       || en_clear || dim_clear; // see RULE_08

    sink_classifier u_classify (
        .clk             (clk),
        .reset_n         (reset_n),
        .sample          (state_r
                          == startup_fault_pkg::ST_DETECT), // see RULE_12
        .led_sink_pin_mv (led_sink_pin_mv),
        .active          (active),
        .shorted         (shorted)
    );

    // Done holds once reached, so a short seen late in the phase still
    // blocks the ramp without losing the count already made.
    assign det_done = det_cnt_r >= startup_fault_pkg::DETECT_CYCLES;

    // The count advances on switching ticks only, so the phase length
    // follows the switching clock rather than the system clock.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            det_cnt_r <= 12'h000;
        end else if (state_r != startup_fault_pkg::ST_DETECT) begin
            det_cnt_r <= 12'h000;
        end else if (sw_tick && !det_done && shorted == 4'h0) begin
            det_cnt_r <= det_cnt_r + 12'h001; // see RULE_13
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            startup_fault_pkg::ST_IDLE: begin
                if (enable && !input_supply_lockout)
                    state_nxt = startup_fault_pkg::ST_WAIT;
            end
            startup_fault_pkg::ST_WAIT: begin
                if (disconnect_on)
                    state_nxt = startup_fault_pkg::ST_UVCHK;
            end
            startup_fault_pkg::ST_UVCHK: begin
                if (output_below_threshold)
                    state_nxt = startup_fault_pkg::ST_LATCH; // see RULE_05
                else if (dimming)
                    state_nxt = startup_fault_pkg::ST_DETECT; // see RULE_12
            end
            startup_fault_pkg::ST_DETECT: begin
                // A short stalls the count; removing it resumes startup.
                if (det_done && shorted == 4'h0) // see RULE_03
                    state_nxt = startup_fault_pkg::ST_RAMP; // see RULE_04
            end
            startup_fault_pkg::ST_RAMP: begin
                state_nxt = startup_fault_pkg::ST_RAMP;
            end
            startup_fault_pkg::ST_LATCH: begin
                // Nothing but a clear request leaves the latch; the override
                // below skips this state so a short enable drop cannot.
                if (clear_req)
                    state_nxt = startup_fault_pkg::ST_IDLE; // see RULE_08
            end
            default: state_nxt = startup_fault_pkg::ST_IDLE;
        endcase
        if (state_r != startup_fault_pkg::ST_LATCH
            && (input_supply_lockout || !enable))
            state_nxt = startup_fault_pkg::ST_IDLE;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            state_r <= startup_fault_pkg::ST_IDLE;
        else
            state_r <= state_nxt; // see RULE_06
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            disconnect_enable         <= 1'b0;
            clock_out_enable          <= 1'b0;
            ramp_enable               <= 1'b0;
            boost_enable              <= 1'b0;
            channel_enable            <= 4'h0;
            sink_short_fault          <= 1'b0;
            output_undervoltage_fault <= 1'b0;
        end else begin
            disconnect_enable <= state_nxt != startup_fault_pkg::ST_IDLE
                && state_nxt != startup_fault_pkg::ST_LATCH;
            // The clock output follows enable and input lockout only, so a dimming clear
            // leaves it running.
            clock_out_enable  <= enable
                                 && !input_supply_lockout; // see RULE_10
            ramp_enable       <= state_nxt == startup_fault_pkg::ST_RAMP;
            boost_enable      <= state_nxt == startup_fault_pkg::ST_RAMP;
            // The mask is the one held before the last detect sample, so a
            // pin that moves in that very cycle shows up one cycle late.
            channel_enable    <= (state_nxt == startup_fault_pkg::ST_RAMP)
                                 ? active : 4'h0; // see RULE_02
            sink_short_fault  <= state_r == startup_fault_pkg::ST_DETECT
                                 && shorted != 4'h0;
            output_undervoltage_fault <=
                state_nxt == startup_fault_pkg::ST_LATCH;
        end
    end

    sequence s_uv_seen;
        state_r == startup_fault_pkg::ST_UVCHK && output_below_threshold;
    endsequence

    a_uv_latch: assert property ( // see RULE_05
        @(posedge clk) disable iff (!reset_n)
        s_uv_seen |=> output_undervoltage_fault && !boost_enable)
        else $error("undervoltage not latched");

    a_latch_holds: assert property ( // see RULE_06
        @(posedge clk) disable iff (!reset_n)
        output_undervoltage_fault && !clear_req |=> output_undervoltage_fault)
        else $error("latched fault dropped without clear");

    a_lockout_clear: assert property ( // see RULE_07
        @(posedge clk) disable iff (!reset_n)
        state_r == startup_fault_pkg::ST_LATCH && input_supply_lockout
        |=> state_r == startup_fault_pkg::ST_IDLE)
        else $error("lockout did not clear fault");

    a_en_clear: assert property ( // see RULE_08
        @(posedge clk) disable iff (!reset_n)
        state_r == startup_fault_pkg::ST_LATCH && en_clear
        |=> !output_undervoltage_fault)
        else $error("enable-low clear failed");

    a_dim_clear: assert property ( // see RULE_09
        @(posedge clk) disable iff (!reset_n)
        state_r == startup_fault_pkg::ST_LATCH && dim_clear
        |=> state_r == startup_fault_pkg::ST_IDLE)
        else $error("dimming-low clear failed");

    a_clkout_run: assert property ( // see RULE_10
        @(posedge clk) disable iff (!reset_n)
        enable && !dimming && !input_supply_lockout |=> clock_out_enable)
        else $error("clock output stopped");

    a_short_holds: assert property ( // see RULE_03
        @(posedge clk) disable iff (!reset_n)
        state_r == startup_fault_pkg::ST_DETECT && shorted != 4'h0
        |=> !ramp_enable && !boost_enable)
        else $error("ramp started with short");

    a_detect_wait: assert property ( // see RULE_13
        @(posedge clk) disable iff (!reset_n)
        state_r == startup_fault_pkg::ST_RAMP
        && $past(state_r) == startup_fault_pkg::ST_DETECT
        |-> $past(det_cnt_r) >= startup_fault_pkg::DETECT_CYCLES)
        else $error("ramp before detect phase end");

    a_unused_off: assert property ( // see RULE_02
        @(posedge clk) disable iff (!reset_n)
        ramp_enable |-> channel_enable == active)
        else $error("channel enables not from detection");

    // The checks below restate the sequencing from outputs, state and counters, so a
    // wrong next-state term shows up even where the bench stays quiet.
    a_detect_stall: assert property ( // see RULE_03
        @(posedge clk) disable iff (!reset_n)
        state_r == startup_fault_pkg::ST_DETECT && shorted != 4'h0
        |=> $stable(det_cnt_r))
        else $error("detect count moved during a short");

    sequence s_recover;
        state_r == startup_fault_pkg::ST_DETECT && det_done
        && shorted == 4'h0 && enable && !input_supply_lockout;
    endsequence

    a_short_recover: assert property ( // see RULE_04
        @(posedge clk) disable iff (!reset_n)
        s_recover |=> ramp_enable && boost_enable)
        else $error("startup did not resume after the short");

    sequence s_dim_start;
        state_r == startup_fault_pkg::ST_UVCHK && dimming
        && !output_below_threshold && enable && !input_supply_lockout;
    endsequence

    a_detect_entry: assert property ( // see RULE_12
        @(posedge clk) disable iff (!reset_n)
        s_dim_start |=> state_r == startup_fault_pkg::ST_DETECT
            && det_cnt_r == 12'h000)
        else $error("sink check did not start on dimming");

    // Holding the classifier still outside detect keeps channel_enable
    // fixed from the second ramp cycle on even if a sink pin wanders.
    a_no_early_check: assert property ( // see RULE_12
        @(posedge clk) disable iff (!reset_n)
        state_r != startup_fault_pkg::ST_DETECT
        |=> $stable(active) && $stable(shorted))
        else $error("sink pins sampled outside detect");

    a_boost_in_ramp: assert property ( // see RULE_03
        @(posedge clk) disable iff (!reset_n)
        boost_enable |-> state_r == startup_fault_pkg::ST_RAMP)
        else $error("boost on outside the ramp");

    a_short_flag: assert property ( // see RULE_03
        @(posedge clk) disable iff (!reset_n)
        sink_short_fault |-> !ramp_enable && !boost_enable)
        else $error("ramp on while a short is flagged");

    a_uv_blocks: assert property ( // see RULE_06
        @(posedge clk) disable iff (!reset_n)
        output_undervoltage_fault |-> !ramp_enable && !disconnect_enable)
        else $error("output stage on while latched off");

    a_drop_to_idle: assert property ( // see RULE_07
        @(posedge clk) disable iff (!reset_n)
        state_r != startup_fault_pkg::ST_LATCH
        && (!enable || input_supply_lockout)
        |=> state_r == startup_fault_pkg::ST_IDLE)
        else $error("disable or lockout did not return to idle");

    a_clkout_stop: assert property ( // see RULE_10
        @(posedge clk) disable iff (!reset_n)
        !enable || input_supply_lockout |=> !clock_out_enable)
        else $error("clock output ran while disabled");

    a_en_clear_gate: assert property ( // see RULE_08
        @(posedge clk) disable iff (!reset_n)
        enable |-> !en_clear)
        else $error("enable clear raised with enable high");

    a_dim_clear_gate: assert property ( // see RULE_09
        @(posedge clk) disable iff (!reset_n)
        !enable || dimming |-> !dim_clear)
        else $error("dimming clear raised without enable high");
endmodule : startup_fault_gate
`default_nettype wire

//--- bench/host_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic want_enable,
    input  wire logic want_dimming,
    output logic      enable,
    output logic      dimming
);
    // Pins are registered, so the device sees a request one cycle late.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enable  <= 1'h0;
            dimming <= 1'h0;
        end else begin
            enable  <= want_enable;
            dimming <= want_dimming;
        end
    end
endmodule : host_ctrl_model
`default_nettype wire

//--- bench/startup_fault_gate_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define check_eq(what, exp, got) begin checks_done++; if ((got) !== (exp)) \
begin num_errors++; $display("unexpected %s expected %0h seen %0h", what, \
exp, got); end end
module startup_fault_gate_tb_top;
    logic        clk, reset_n, sw_tick, low_freq_variant, enable, dimming;
    logic        want_enable, want_dimming, input_supply_lockout;
    logic        disconnect_on, output_below_threshold;
    logic [39:0] led_sink_pin_mv;
    logic        disconnect_enable, clock_out_enable, ramp_enable;
    logic        boost_enable, sink_short_fault, output_undervoltage_fault;
    logic [3:0]  channel_enable;
    int          num_errors = 0;
    int          checks_done = 0;
    int          seed = 15;
    int          cycles = 0;
    int          n, gaps;
    logic [39:0] pins;

    startup_fault_gate startup_fault_gate_i (.clk(clk), .reset_n(reset_n),
        .sw_tick(sw_tick), .low_freq_variant(low_freq_variant),
        .enable(enable), .dimming(dimming),
        .input_supply_lockout(input_supply_lockout),
        .disconnect_on(disconnect_on),
        .output_below_threshold(output_below_threshold),
        .led_sink_pin_mv(led_sink_pin_mv),
        .disconnect_enable(disconnect_enable),
        .clock_out_enable(clock_out_enable), .ramp_enable(ramp_enable),
        .boost_enable(boost_enable), .channel_enable(channel_enable),
        .sink_short_fault(sink_short_fault),
        .output_undervoltage_fault(output_undervoltage_fault));
    host_ctrl_model host_ctrl_model_i (.clk(clk), .reset_n(reset_n),
        .want_enable(want_enable), .want_dimming(want_dimming),
        .enable(enable), .dimming(dimming));

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // The longest path is the 32k clear; the ceiling leaves a small margin.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 95000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic edges(input int k);
        repeat (k) @(posedge clk);
    endtask : edges

    function automatic logic [9:0] pick_mv();
        logic [9:0] v;
        v = 10'($random(seed));
        if (v < startup_fault_pkg::SHORT_MV)
            v = v + startup_fault_pkg::SHORT_MV;
        return v;
    endfunction : pick_mv

    function automatic logic [3:0] exp_active(input logic [39:0] p);
        logic [3:0] m;
        for (int i = 0; i < 4; i++) begin
            m[i] = p[i*10 +: 10] > startup_fault_pkg::ACTIVE_MV;
        end
        return m;
    endfunction : exp_active

    task automatic begin_run(input logic [39:0] p);
        edges(1);
        led_sink_pin_mv        <= p;
        output_below_threshold <= 1'h0;
        want_enable            <= 1'h1;
        disconnect_on          <= 1'h1;
        edges(20);
        @(negedge clk);
        `check_eq("disconnect_enable", 1'h1, disconnect_enable)
        `check_eq("short early", 1'h0, sink_short_fault)
        `check_eq("ramp early", 1'h0, ramp_enable)
        edges(1);
        want_dimming <= 1'h1;
    endtask : begin_run

    task automatic wait_ramp(input int lo, input logic [39:0] p);
        n = 0;
        while (ramp_enable !== 1'h1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        `check_eq("ramp delay", 1'h1, 1'(n >= lo && n <= 3600))
        `check_eq("boost_enable", 1'h1, boost_enable)
        `check_eq("channel_enable", exp_active(p),
            channel_enable)
        edges(1);
        want_enable   <= 1'h0;
        want_dimming  <= 1'h0;
        disconnect_on <= 1'h0;
        edges(5);
    endtask : wait_ramp

    task automatic make_fault(input logic dim);
        edges(1);
        want_enable            <= 1'h1;
        want_dimming           <= dim;
        disconnect_on          <= 1'h1;
        output_below_threshold <= 1'h1;
        edges(20);
        @(negedge clk);
        `check_eq("uv fault", 1'h1, output_undervoltage_fault)
        `check_eq("disconnect off", 1'h0, disconnect_enable)
        `check_eq("ramp in fault", 1'h0, ramp_enable)
        edges(1);
        disconnect_on          <= 1'h0;
        output_below_threshold <= 1'h0;
    endtask : make_fault

    task automatic wait_clear();
        n = 0;
        while (output_undervoltage_fault !== 1'h0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        `check_eq("fault cleared", 1'h0,
            output_undervoltage_fault)
    endtask : wait_clear

    initial begin
        reset_n = 1'h0;
        sw_tick = 1'h1;
        low_freq_variant = 1'h1;
        want_enable = 1'h0;
        want_dimming = 1'h0;
        input_supply_lockout = 1'h0;
        disconnect_on = 1'h0;
        output_below_threshold = 1'h0;
        led_sink_pin_mv = 40'h0;
        edges(2);
        reset_n <= 1'h1;
        @(negedge clk);
        `check_eq("outputs after reset", 1'h0,
            ramp_enable | disconnect_enable | boost_enable)
        pins = {10'h154, 10'h155, 10'h078, 10'h3ff};
        begin_run(pins);
        wait_ramp(3584, pins);
        pins = {pick_mv(), pick_mv(), pick_mv(), pick_mv()};
        begin_run(pins);
        wait_ramp(3584, pins);
        pins = {pick_mv(), 10'h077, pick_mv(), pick_mv()};
        begin_run(pins);
        edges(4000);
        @(negedge clk);
        `check_eq("short flagged", 1'h1, sink_short_fault)
        `check_eq("boost held off", 1'h0, boost_enable)
        edges(1);
        pins[29:20] = 10'h200;
        led_sink_pin_mv <= pins;
        wait_ramp(3000, pins);
        make_fault(1'h1);
        want_enable <= 1'h0;
        edges(4000);
        want_enable <= 1'h1;
        edges(3);
        want_enable <= 1'h0;
        edges(8191);
        @(negedge clk);
        `check_eq("fault held", 1'h1, output_undervoltage_fault)
        wait_clear();
        edges(1);
        low_freq_variant <= 1'h0;
        make_fault(1'h1);
        want_dimming <= 1'h0;
        edges(20000);
        want_dimming <= 1'h1;
        edges(3);
        want_dimming <= 1'h0;
        gaps = 0;
        repeat (32767) begin
            @(negedge clk);
            gaps += (clock_out_enable !== 1'h1);
        end
        `check_eq("fault held long", 1'h1,
            output_undervoltage_fault)
        wait_clear();
        `check_eq("clock gaps", 0, gaps)
        make_fault(1'h1);
        input_supply_lockout <= 1'h1;
        edges(2);
        @(negedge clk);
        `check_eq("lockout clear", 1'h0,
            output_undervoltage_fault)
        give_verdict();
    end
endmodule : startup_fault_gate_tb_top
`default_nettype wire
